// ==== rtl/fotim_decode.sv ====
`timescale 1ns/1ps
`include "fotim_map.svh"

module fotim_decode
(
   input wire logic [3:0] digit,
   input wire logic [`FOTIM_CONTACTS-1:0] contacts,
   output logic permit,
   output fotim_pkg::fotim_mode_t mode
);

   logic [2:0] index;

   // ---------------------------------------------------------------
   // Digit to contact and sense
   // ---------------------------------------------------------------
   always_comb
   begin
      index = 3'h0;
      mode = fotim_pkg::FOTIM_MODE_BLOCK;
      unique case (digit)
         4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6:
         begin
            mode = fotim_pkg::FOTIM_MODE_CLOSED;
            index = 3'(digit - 4'h1);
         end
         4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF:
         begin
            mode = fotim_pkg::FOTIM_MODE_OPEN;
            index = 3'(digit - 4'hA);
         end
         4'h8, 4'h9:
         begin
            mode = fotim_pkg::FOTIM_MODE_FREE;
         end
         default:
         begin
            mode = fotim_pkg::FOTIM_MODE_BLOCK;
         end
      endcase
   end

   always_comb
   begin
      unique case (mode)
         fotim_pkg::FOTIM_MODE_CLOSED: permit = contacts[index];
         fotim_pkg::FOTIM_MODE_OPEN: permit = ~contacts[index];
         fotim_pkg::FOTIM_MODE_FREE: permit = 1'b1;
         fotim_pkg::FOTIM_MODE_BLOCK: permit = 1'b0;
      endcase
   end

endmodule : fotim_decode

// ==== rtl/fotim_map.svh ====
`ifndef FOTIM_MAP_SVH
`define FOTIM_MAP_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define FOTIM_OFF_SELECT 12'h000
`define FOTIM_OFF_CONTROL 12'h004
`define FOTIM_OFF_STATUS 12'h008
`define FOTIM_OFF_ACTIVE 12'h00C

// ---------------------------------------------------------------
// Field positions and values
// ---------------------------------------------------------------
`define FOTIM_SEL_RESET 16'h1881
`define FOTIM_SEL_MAX 16'hFFF1
`define FOTIM_CTRL_RESTART_BIT 0
`define FOTIM_ST_PERMIT_BIT 0
`define FOTIM_ST_PENDING_BIT 1
`define FOTIM_ST_CONTACT_LSB 8
`define FOTIM_ST_DIGIT_LSB 16
`define FOTIM_CONTACTS 6
`define FOTIM_ADDR_W 12

`endif

// ==== rtl/fotim_pkg.sv ====
package fotim_pkg;

   // Meaning of the lowest digit of the selection setting
   typedef enum logic [1:0]
   {
      FOTIM_MODE_BLOCK = 2'b00,
      FOTIM_MODE_FREE = 2'b01,
      FOTIM_MODE_CLOSED = 2'b10,
      FOTIM_MODE_OPEN = 2'b11
   } fotim_mode_t;

   typedef logic [15:0] fotim_word_t;

endpackage : fotim_pkg

// ==== rtl/fotim_sync.sv ====
`timescale 1ns/1ps
`include "fotim_map.svh"

module fotim_sync
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [`FOTIM_CONTACTS-1:0] async_in,
   output logic [`FOTIM_CONTACTS-1:0] sync_out
);

   logic [`FOTIM_CONTACTS-1:0] meta_q;
   logic [`FOTIM_CONTACTS-1:0] meta_d;
   logic [`FOTIM_CONTACTS-1:0] sync_q;
   logic [`FOTIM_CONTACTS-1:0] sync_d;

   // ---------------------------------------------------------------
   // Two flip-flops per contact
   // ---------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < `FOTIM_CONTACTS; i++)
      begin : g_bit
         always_comb
         begin
            meta_d[i] = async_in[i];
            sync_d[i] = meta_q[i];
         end

         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               meta_q[i] <= 1'b0;
               sync_q[i] <= 1'b0;
            end
            else
            begin
               meta_q[i] <= meta_d[i];
               sync_q[i] <= sync_d[i];
            end
         end
      end
   endgenerate

   assign sync_out = sync_q;

endmodule : fotim_sync

// ==== rtl/fotim_top.sv ====
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "fotim_map.svh"

// Function
// - Forward travel is inhibited while the mapped contact is in its prohibiting state.
// - Sixteen-bit setting up to FFF1, default 1881, applied only at restart.
// - Digit B uses the second contact inverted; open permits forward run.
// - Digit C uses the third contact inverted; open permits forward run.
module fotim_top
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [`FOTIM_CONTACTS-1:0] main_io_connector,
   output logic forward_overtravel_permit
);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   fotim_pkg::fotim_word_t select_q;
   fotim_pkg::fotim_word_t select_d;
   fotim_pkg::fotim_word_t active_q;
   fotim_pkg::fotim_word_t active_d;
   logic [31:0] prdata_q;
   logic [31:0] prdata_d;
   logic err_q;
   logic err_d;
   logic permit_q;
   logic permit_d;
   logic restart_q;
   logic restart_d;
   logic [`FOTIM_CONTACTS-1:0] contacts;
   logic permit_raw;
   fotim_pkg::fotim_mode_t mode;
   logic setup;
   logic access;
   logic [`FOTIM_ADDR_W-1:0] addr;
   logic hit_select;
   logic hit_control;
   logic hit_status;
   logic hit_active;
   logic mapped;
   fotim_pkg::fotim_word_t wr_value;
   logic wr_in_range;
   logic wr_select;
   logic wr_restart;
   logic pending;
   logic [31:0] status_word;

   // ---------------------------------------------------------------
   // Contact synchroniser
   // ---------------------------------------------------------------
   fotim_sync u_sync
   (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(main_io_connector),
      .sync_out(contacts)
   );

   // ---------------------------------------------------------------
   // Mapping decoder on the active setting
   // ---------------------------------------------------------------
   fotim_decode u_decode
   (
      .digit(active_q[3:0]),
      .contacts(contacts),
      .permit(permit_raw),
      .mode(mode)
   );

   // ---------------------------------------------------------------
   // Bus phase and address decode
   // ---------------------------------------------------------------
   always_comb
   begin
      setup = psel & ~penable;
      access = psel & penable;
      addr = paddr[`FOTIM_ADDR_W-1:0];
      hit_select = (addr == `FOTIM_OFF_SELECT);
      hit_control = (addr == `FOTIM_OFF_CONTROL);
      hit_status = (addr == `FOTIM_OFF_STATUS);
      hit_active = (addr == `FOTIM_OFF_ACTIVE);
      mapped = (paddr[31:`FOTIM_ADDR_W] == 20'h00000)
         & (hit_select | hit_control | hit_status | hit_active);
   end

   // ---------------------------------------------------------------
   // Write value with byte lanes
   // ---------------------------------------------------------------
   always_comb
   begin
      wr_value[7:0] = pstrb[0] ? pwdata[7:0] : select_q[7:0];
      wr_value[15:8] = pstrb[1] ? pwdata[15:8] : select_q[15:8];
      wr_in_range = (wr_value <= `FOTIM_SEL_MAX);
   end

   // ---------------------------------------------------------------
   // Setup-phase answer: error flag and read data
   // ---------------------------------------------------------------
   always_comb
   begin
      status_word = 32'h00000000;
      status_word[`FOTIM_ST_PERMIT_BIT] = permit_q;
      status_word[`FOTIM_ST_PENDING_BIT] = pending;
      status_word[`FOTIM_ST_CONTACT_LSB +: `FOTIM_CONTACTS] = contacts;
      status_word[`FOTIM_ST_DIGIT_LSB +: 2] = mode;
   end

   always_comb
   begin
      err_d = err_q;
      prdata_d = prdata_q;
      if (setup)
      begin
         err_d = ~mapped
            | (pwrite & hit_select & ~wr_in_range)
            | (pwrite & (hit_status | hit_active));
         prdata_d = 32'h00000000;
         if (!pwrite)
         begin
            if (hit_select)
            begin
               prdata_d = {16'h0000, select_q};
            end
            else if (hit_status)
            begin
               prdata_d = status_word;
            end
            else if (hit_active)
            begin
               prdata_d = {16'h0000, active_q};
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         err_q <= 1'b0;
         prdata_q <= 32'h00000000;
      end
      else
      begin
         err_q <= err_d;
         prdata_q <= prdata_d;
      end
   end

   assign pready = access;
   assign pslverr = access & err_q;
   assign prdata = prdata_q;

   // ---------------------------------------------------------------
   // Stored setting and restart latch
   // ---------------------------------------------------------------
   always_comb
   begin
      wr_select = access & pwrite & ~err_q & hit_select;
      wr_restart = access & pwrite & ~err_q & hit_control
         & pstrb[0] & pwdata[`FOTIM_CTRL_RESTART_BIT];
      pending = (select_q != active_q);
   end

   always_comb
   begin
      select_d = select_q;
      active_d = active_q;
      restart_d = wr_restart;
      if (wr_select)
      begin
         select_d = wr_value;
      end
      if (restart_q)
      begin
         active_d = select_q;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         select_q <= `FOTIM_SEL_RESET;
         active_q <= `FOTIM_SEL_RESET;
         restart_q <= 1'b0;
      end
      else
      begin
         select_q <= select_d;
         active_q <= active_d;
         restart_q <= restart_d;
      end
   end

   // ---------------------------------------------------------------
   // Forward run qualifier
   // ---------------------------------------------------------------
   always_comb
   begin
      permit_d = permit_raw;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         permit_q <= 1'b0;
      end
      else
      begin
         permit_q <= permit_d;
      end
   end

   assign forward_overtravel_permit = permit_q;

endmodule : fotim_top

// ==== tb/fotim_asserts.sv ====
`timescale 1ns/1ps
`include "fotim_map.svh"

module fotim_asserts
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic pslverr,
   input wire logic [`FOTIM_CONTACTS-1:0] main_io_connector,
   input wire logic forward_overtravel_permit
);
   logic [15:0] pend_q, act_q, wv;
   logic [5:0] s1_q, s2_q;
   logic go_q, wr0, fp;
   logic [3:0] dg;
   // Shadow of pending and active setting
   always_comb
   begin
      wv = {pstrb[1] ? pwdata[15:8] : pend_q[15:8], pstrb[0] ? pwdata[7:0] : pend_q[7:0]};
      wr0 = psel && penable && pwrite && paddr == 32'h0;
      dg = act_q[3:0];
      fp = forward_overtravel_permit;
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pend_q <= `FOTIM_SEL_RESET;
         act_q <= `FOTIM_SEL_RESET;
         go_q <= 1'b0;
         s1_q <= '0;
         s2_q <= '0;
      end
      else
      begin
         pend_q <= (wr0 && wv <= `FOTIM_SEL_MAX) ? wv : pend_q;
         act_q <= go_q ? pend_q : act_q;
         go_q <= psel && penable && pwrite && paddr == 32'h4 && pstrb[0] && pwdata[0];
         s1_q <= main_io_connector;
         s2_q <= s1_q;
      end
   end
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence s_bad_write;
      wr0 && wv > `FOTIM_SEL_MAX;
   endsequence
   a_range_refuse: assert property (s_bad_write |-> pslverr)
      else $error("oversize write taken");
   a_inhibit_open: assert property ((dg == 4'h1 && !main_io_connector[0]) [*4] |-> !fp)
      else $error("open contact not inhibiting");
   a_closed_map: assert property (dg inside {[4'h1:4'h6]} |=> fp == $past(s2_q[dg-4'h1]))
      else $error("closed map wrong");
   a_open_b: assert property (dg == 4'hB |=> fp == !$past(s2_q[1]))
      else $error("code B wrong");
   a_open_c: assert property (dg == 4'hC |=> fp == !$past(s2_q[2]))
      else $error("code C wrong");
   a_fixed_codes: assert property (dg inside {4'h7, 4'h8} |=> fp == ($past(dg) == 4'h8))
      else $error("fixed code wrong");
endmodule : fotim_asserts

bind fotim_top fotim_asserts u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
   .pstrb, .pslverr, .main_io_connector, .forward_overtravel_permit);

// ==== tb/fotim_contacts.sv ====
`timescale 1ns/1ps
`include "fotim_map.svh"

module fotim_contacts
(
   input wire logic pclk,
   input wire logic [`FOTIM_CONTACTS-1:0] want,
   input wire logic slow,
   output logic [`FOTIM_CONTACTS-1:0] contacts
);
   logic [`FOTIM_CONTACTS-1:0] mid_q;
   // Slow switches settle one cycle later
   always_ff @(posedge pclk)
   begin
      mid_q <= want;
      contacts <= slow ? mid_q : want;
   end
endmodule : fotim_contacts

// ==== tb/tb_forward_overtravel_input_map.sv ====
`timescale 1ns/1ps
`include "fotim_map.svh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_fail++; $display("unexpected at %0t: mismatch", $time); end end

module tb_forward_overtravel_input_map;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0;
   logic pready, pslverr, permit, err;
   logic [31:0] paddr = '0, pwdata = '0, prdata, rd, seed = 32'h6681E24A;
   logic [3:0] pstrb = 4'hF;
   logic [5:0] want = '0, io;
   int n_fail = 0, checks_done = 0;
   localparam logic [31:0] SEL = {20'h0, `FOTIM_OFF_SELECT}, CTL = {20'h0, `FOTIM_OFF_CONTROL};
   always #25 pclk = ~pclk;
   fotim_contacts u_sw (.pclk(pclk), .want(want), .slow(slow), .contacts(io));
   fotim_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .main_io_connector(io), .forward_overtravel_permit(permit));
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   function automatic logic exp_p(input logic [3:0] d, input logic [5:0] c);
      if (d inside {[4'h1:4'h6]})
         return c[d - 4'h1];
      if (d >= 4'hA)
         return !c[d - 4'hA];
      return d inside {4'h8, 4'h9};
   endfunction : exp_p
   task test_done;
      $display("checks %0d, mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : test_done
   task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      int i;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do
      begin
         @(posedge pclk);
         i++;
      end
      while (pready !== 1'b1 && i < 20);
      if (pready !== 1'b1)
      begin
         n_fail++;
         test_done();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task settle(input logic [3:0] d);
      logic [31:0] r;
      r = rnd();
      want <= r[5:0];
      slow <= r[6];
      repeat (6) @(posedge pclk);
      `CHK(permit, exp_p(d, r[5:0]));
   endtask : settle
   initial
   begin
      logic [3:0] old;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, SEL, '0);
      `CHK(rd[15:0], `FOTIM_SEL_RESET);
      old = 4'h1;
      for (int k = 0; k < 16; k++)
      begin
         apb(1'b1, SEL, {20'h188, 4'(k)});
         `CHK(err, 1'b0);
         settle(old);
         apb(1'b0, {20'h0, `FOTIM_OFF_STATUS}, '0);
         `CHK(rd[`FOTIM_ST_PENDING_BIT], 4'(k) != old);
         apb(1'b1, CTL, 32'h1);
         settle(4'(k));
         settle(4'(k));
         apb(1'b0, {20'h0, `FOTIM_OFF_STATUS}, '0);
         `CHK(rd[`FOTIM_ST_PENDING_BIT], 1'b0);
         apb(1'b0, CTL, '0);
         `CHK(rd, 32'h00000000);
         old = 4'(k);
         $display("digit %0h done", k);
      end
      pstrb <= 4'h1;
      apb(1'b1, SEL, 32'hFFFFFF82);
      pstrb <= 4'hF;
      apb(1'b1, SEL, 32'hFFF2);
      `CHK(err, 1'b1);
      apb(1'b0, SEL, '0);
      `CHK(rd[15:0], 16'h1882);
      apb(1'b0, 32'h10, '0);
      `CHK(err, 1'b1);
      $display("refusal tests done");
      presetn <= 1'b0;
      @(posedge pclk);
      `CHK(permit, 1'b0);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, {20'h0, `FOTIM_OFF_ACTIVE}, '0);
      `CHK(rd[15:0], `FOTIM_SEL_RESET);
      test_done();
   end
endmodule : tb_forward_overtravel_input_map
